// ---- core/orp_rom.sv ----
// Purpose: on-chip program rom with cpu read port and byte-wide prom mode
// Assumes: boot pins static while running; prom mode pins from a programmer
// Notes:   array is one-time programmable, a pulse can only clear bits
// Operation
// - cpu reads of bytes and words complete in two states over 16-bit data.
// - codes 001 to 100 disable the rom as external area, 101 to 111 enable it.
// - array size and address decode follow the member capacity of 64, 48 or 32 kbyte.
// - in prom mode the cpu side is suspended and the array is byte-wide to the pins.
// - programming is one byte per strobe pulse, never a page.
// - never programmed locations read back as ff.
// - output enable and strobe select program, verify or high impedance; address is input.
//
// The placing of the registers and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/100ps
module orp_rom
  import orp_pkg::*;
#(
  parameter int unsigned ROM_BYTES   = orp_pkg::ROM_BYTES_DEF,
  parameter int unsigned OPW_MAX_CYC = orp_pkg::OPW_MAX_CYC
) (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // wishbone classic slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  // cpu read port
  input  wire logic                      cpu_req,
  input  wire orp_pkg::orp_cpu_req_s     cpu_req_info,
  output logic                           cpu_ack,
  output logic                           cpu_ext,
  output logic      [15:0]               cpu_rdata,
  output logic                           rom_enabled,
  output logic                           mcu_suspend,
  // device pins
  input  wire logic                      boot_cfg_pin_hi,
  input  wire logic                      boot_cfg_pin_mid,
  input  wire logic                      boot_cfg_pin_lo,
  input  wire logic                      hw_standby_input_n,
  input  wire logic                      port5_bit1_pin,
  input  wire logic                      port5_bit0_pin,
  input  wire logic                      program_strobe_n,
  input  wire logic                      prom_oe_n,
  input  wire logic [orp_pkg::PROM_AW-1:0] prom_address_pins,
  input  wire logic [7:0]                prom_data_pins_i,
  output logic      [7:0]                prom_data_pins_o,
  output logic                           prom_data_pins_oe
);
  import orp_pkg::*;

  localparam int unsigned RA_W = $clog2(ROM_BYTES);

  typedef enum logic [1:0] {C_IDLE, C_STATE1, C_STATE2} orp_cpu_st_e;
  typedef enum logic {P_IDLE, P_PULSE} orp_prom_st_e;

  // array; erased cells are all ones, reset never touches them
  logic [7:0] mem [ROM_BYTES] = '{default: ERASED_BYTE};

  // pins into the clock domain
  orp_pins_s pins;
  orp_sync #(.W(PIN_W)) u_sync (
    .clk (clk),
    .rstn(rstn),
    .d   ({boot_cfg_pin_hi, boot_cfg_pin_mid, boot_cfg_pin_lo, hw_standby_input_n,
           port5_bit1_pin, port5_bit0_pin, program_strobe_n, prom_oe_n,
           prom_address_pins, prom_data_pins_i}),
    .q   (pins)
  );

  // mode decode state
  logic prom_mode_reg, prom_mode_next;
  logic rom_en_reg, rom_en_next;
  always_comb begin
    prom_mode_next = (pins.cfg == MODE_PROM) && !pins.hw_standby_input_n_n
                     && pins.p5_1 && pins.p5_0;
    rom_en_next    = (pins.cfg >= MODE_ROM_MIN);
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prom_mode_reg <= 1'b0;
      rom_en_reg    <= 1'b0;
    end else begin
      prom_mode_reg <= prom_mode_next;
      rom_en_reg    <= rom_en_next;
    end
  end

  // register block state
  logic        prog_en_reg, prog_en_next;
  logic        perr_reg, perr_next;
  logic [15:0] pcount_reg, pcount_next;
  logic        ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  // programming datapath
  logic        wr_en;
  logic [RA_W-1:0] wr_addr;
  logic        pulse_bad;

  // wishbone: ack one cycle after strobe, dropped the following cycle
  always_comb begin
    logic hit;
    hit          = wb_cyc_i && wb_stb_i && !ack_reg;
    ack_next     = hit;
    dat_next     = 32'h0;
    prog_en_next = prog_en_reg;
    perr_next    = perr_reg;
    pcount_next  = pcount_reg;
    if (hit && wb_we_i && wb_sel_i[0]) begin
      if (wb_adr_i == REG_CTRL) begin
        prog_en_next = wb_dat_i[CT_PROG_EN];
      end
      if (wb_adr_i == REG_STATUS && wb_dat_i[ST_PULSE_ERR]) begin
        perr_next = 1'b0;
      end
    end
    if (hit && !wb_we_i) begin
      case (wb_adr_i)
        REG_STATUS: begin
          dat_next[ST_MODE_LSB +: 3] = pins.cfg;
          dat_next[ST_ROM_EN]        = rom_en_reg;
          dat_next[ST_PROM]          = prom_mode_reg;
          dat_next[ST_PULSE_ERR]     = perr_reg;
        end
        REG_CTRL:  dat_next[CT_PROG_EN] = prog_en_reg;
        REG_COUNT: dat_next[15:0]       = pcount_reg;
        default:   dat_next = 32'h0;
      endcase
    end
    // hardware events win over a same-cycle clear
    if (pulse_bad) begin
      perr_next = 1'b1;
    end
    if (wr_en) begin
      pcount_next = pcount_reg + 16'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ack_reg     <= 1'b0;
      dat_reg     <= 32'h0;
      prog_en_reg <= CT_PROG_EN_RST;
      perr_reg    <= 1'b0;
      pcount_reg  <= 16'h0;
    end else begin
      ack_reg     <= ack_next;
      dat_reg     <= dat_next;
      prog_en_reg <= prog_en_next;
      perr_reg    <= perr_next;
      pcount_reg  <= pcount_next;
    end
  end

  // cpu read sequencer: two states per access
  orp_cpu_st_e  cst_reg, cst_next;
  orp_cpu_req_s creq_reg, creq_next;
  logic         cack_reg, cack_next;
  logic         cext_reg, cext_next;
  logic [15:0]  cdat_reg, cdat_next;
  always_comb begin
    logic [RA_W-1:0] a;
    logic            in_rng;
    a         = creq_reg.addr[RA_W-1:0];
    in_rng    = ({16'h0, creq_reg.addr} < 32'(ROM_BYTES));
    cst_next  = cst_reg;
    creq_next = creq_reg;
    cack_next = 1'b0;
    cext_next = 1'b0;
    cdat_next = cdat_reg;
    case (cst_reg)
      C_IDLE: begin
        // suspended entirely while the programmer owns the array
        if (cpu_req && !prom_mode_reg) begin
          if (rom_en_reg) begin
            creq_next = cpu_req_info;
            cst_next  = C_STATE1;
          end else begin
            cext_next = 1'b1;
          end
        end
      end
      C_STATE1: begin
        cst_next  = C_STATE2;
        cack_next = 1'b1;
        if (!in_rng) begin
          cdat_next = {ERASED_BYTE, ERASED_BYTE};
        end else if (creq_reg.word) begin
          // word uses full bus, even address, high byte first
          cdat_next = {mem[{a[RA_W-1:1], 1'b0}], mem[{a[RA_W-1:1], 1'b1}]};
        end else begin
          // byte travels on the upper half of the bus
          cdat_next = {mem[a], 8'h0};
        end
      end
      C_STATE2: cst_next = C_IDLE;
      default:  cst_next = C_IDLE;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cst_reg  <= C_IDLE;
      creq_reg <= '0;
      cack_reg <= 1'b0;
      cext_reg <= 1'b0;
      cdat_reg <= 16'h0;
    end else begin
      cst_reg  <= cst_next;
      creq_reg <= creq_next;
      cack_reg <= cack_next;
      cext_reg <= cext_next;
      cdat_reg <= cdat_next;
    end
  end

  // prom pin state machine: one strobe pulse programs one byte
  orp_prom_st_e        pst_reg, pst_next;
  logic [PCNT_W-1:0]   pw_reg, pw_next;
  logic [PROM_AW-1:0]  paddr_reg, paddr_next;
  logic [7:0]          pdata_reg, pdata_next;
  logic [7:0]          dout_reg, dout_next;
  logic                doe_reg, doe_next;
  logic                verify_st, program_st;
  always_comb begin
    logic in_rng;
    verify_st  = prom_mode_reg && !pins.oe_n && pins.pgm_n;
    program_st = prom_mode_reg && pins.oe_n && !pins.pgm_n;
    in_rng     = ({15'h0, pins.addr} < 32'(ROM_BYTES));
    pst_next   = pst_reg;
    pw_next    = pw_reg;
    paddr_next = paddr_reg;
    pdata_next = pdata_reg;
    wr_en      = 1'b0;
    pulse_bad  = 1'b0;
    wr_addr    = paddr_reg[RA_W-1:0];
    case (pst_reg)
      P_IDLE: begin
        if (program_st && prog_en_reg) begin
          pst_next   = P_PULSE;
          pw_next    = '0;
          paddr_next = pins.addr;
          pdata_next = pins.data;
        end
      end
      P_PULSE: begin
        if (pw_reg != '1) begin
          pw_next = pw_reg + PCNT_W'(1);
        end
        // track setup data during the pulse, latch at its end
        paddr_next = pins.addr;
        pdata_next = pins.data;
        if (!program_st) begin
          pst_next = P_IDLE;
          if (pw_reg >= PCNT_W'(PW_MIN_CYC) && pw_reg <= PCNT_W'(OPW_MAX_CYC)
              && ({15'h0, paddr_reg} < 32'(ROM_BYTES))) begin
            wr_en = 1'b1;
          end else begin
            pulse_bad = 1'b1;
          end
        end
      end
      default: pst_next = P_IDLE;
    endcase
    // verify drives stored data, everything else floats
    doe_next  = verify_st;
    dout_next = in_rng ? mem[pins.addr[RA_W-1:0]] : ERASED_BYTE;
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pst_reg   <= P_IDLE;
      pw_reg    <= '0;
      paddr_reg <= '0;
      pdata_reg <= 8'h0;
      dout_reg  <= 8'h0;
      doe_reg   <= 1'b0;
    end else begin
      pst_reg   <= pst_next;
      pw_reg    <= pw_next;
      paddr_reg <= paddr_next;
      pdata_reg <= pdata_next;
      dout_reg  <= dout_next;
      doe_reg   <= doe_next;
    end
  end

  // otp cell: a pulse can only pull bits to zero
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= mem[wr_addr] & pdata_reg;
    end
  end

  // outputs straight from flops
  assign wb_ack_o          = ack_reg;
  assign wb_dat_o          = dat_reg;
  assign cpu_ack           = cack_reg;
  assign cpu_ext           = cext_reg;
  assign cpu_rdata         = cdat_reg;
  assign rom_enabled       = rom_en_reg;
  assign mcu_suspend       = prom_mode_reg;
  assign prom_data_pins_o  = dout_reg;
  assign prom_data_pins_oe = doe_reg;

  AST_CPU_TWO_STATES: assert property (@(posedge clk) disable iff (!rstn)
    (cst_reg == C_IDLE && cpu_req && !prom_mode_reg && rom_en_reg) |-> ##1 !cpu_ack ##1 cpu_ack)
    else $error("cpu access not answered in two states");
  AST_EXT_AREA: assert property (@(posedge clk) disable iff (!rstn)
    (cst_reg == C_IDLE && cpu_req && !prom_mode_reg && !rom_en_reg) |=> cpu_ext && !cpu_ack)
    else $error("disabled rom not treated as external area");
  AST_ROM_ONLY_ENABLED: assert property (@(posedge clk) disable iff (!rstn)
    cpu_ext |-> !$past(rom_en_reg))
    else $error("external flag with rom enabled");
  AST_SUSPEND: assert property (@(posedge clk) disable iff (!rstn)
    (prom_mode_reg && cst_reg == C_IDLE) |=> cst_reg == C_IDLE && !cpu_ext)
    else $error("cpu access while suspended");
  AST_VERIFY_DRIVE: assert property (@(posedge clk) disable iff (!rstn)
    verify_st |=> prom_data_pins_oe)
    else $error("verify state does not drive data");
  AST_PROGRAM_FLOAT: assert property (@(posedge clk) disable iff (!rstn)
    !verify_st |=> !prom_data_pins_oe)
    else $error("data pins driven outside verify");
  AST_ERASED_ABOVE: assert property (@(posedge clk) disable iff (!rstn)
    ({15'h0, pins.addr} >= 32'(ROM_BYTES)) |=> prom_data_pins_o == ERASED_BYTE)
    else $error("unimplemented location not ff");
  AST_ONE_BYTE: assert property (@(posedge clk) disable iff (!rstn)
    wr_en |=> !wr_en ##1 !wr_en)
    else $error("more than one byte per pulse");
  AST_PULSE_MIN: assert property (@(posedge clk) disable iff (!rstn)
    wr_en |-> pw_reg >= PCNT_W'(PW_MIN_CYC))
    else $error("short pulse programmed a byte");
  AST_WB_ACK: assert property (@(posedge clk) disable iff (!rstn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not one cycle after strobe");

endmodule : orp_rom

// ---- core/orp_pkg.sv ----
// Purpose: shared constants and carriers for the on-chip program rom block
// Assumes: 10 mhz system clock, wishbone classic register port
// Notes:   times kept in ns, cycle counts derived from the clock period
package orp_pkg;

  // clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // rom geometry
  localparam int unsigned ROM_BYTES_DEF = 65536;
  localparam int unsigned CPU_AW        = 16;
  localparam int unsigned PROM_AW       = 17;
  localparam logic [7:0]  ERASED_BYTE   = 8'hff;

  // boot configuration codes
  localparam logic [2:0] MODE_PROM     = 3'h0;
  localparam logic [2:0] MODE_ROM_MIN  = 3'h5;

  // program strobe pulse limits
  localparam int unsigned PW_MIN_NS  = 190000;  // 0.19 ms
  localparam int unsigned PW_NOM_NS  = 200000;  // 0.20 ms nominal
  localparam int unsigned OPW_MAX_NS = 5250000; // 5.25 ms
  localparam int unsigned PW_MIN_CYC =
    (PW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OPW_MAX_CYC = OPW_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned PCNT_W = 16;

  // register map (byte addresses)
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CTRL   = 8'h04;
  localparam logic [7:0] REG_COUNT  = 8'h08;

  // status fields
  localparam int unsigned ST_MODE_LSB  = 0;
  localparam int unsigned ST_ROM_EN    = 3;
  localparam int unsigned ST_PROM      = 4;
  localparam int unsigned ST_PULSE_ERR = 5;
  // control fields
  localparam int unsigned CT_PROG_EN   = 0;
  localparam logic        CT_PROG_EN_RST = 1'b1;

  // synchronised pin group layout width
  localparam int unsigned PIN_W = 3 + 1 + 2 + 1 + 1 + PROM_AW + 8;

  // pins seen through the synchroniser
  typedef struct packed {
    logic [2:0]         cfg;
    logic               hw_standby_input_n_n;
    logic               p5_1;
    logic               p5_0;
    logic               pgm_n;
    logic               oe_n;
    logic [PROM_AW-1:0] addr;
    logic [7:0]         data;
  } orp_pins_s;

  // cpu read request
  typedef struct packed {
    logic [CPU_AW-1:0] addr;
    logic              word;
  } orp_cpu_req_s;

endpackage : orp_pkg

// ---- core/orp_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk
// Notes:   output follows once stages two and three agree
`timescale 1ns/100ps
module orp_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
  logic [W-1:0] q_next;

  // accept per bit only when the last two stages match
  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
    end
  end

  // stage one feeds stage two only
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;

endmodule : orp_sync

// ---- verif/orp_prog_model.sv ----
// Purpose: programmer and boot pin model facing the rom block pins
// Assumes: pins change just after rising clk edges
// Notes:   a released data line shows the inverse of its last value
`timescale 1ns/100ps
module orp_prog_model (
  input  wire logic                        clk,
  input  wire logic [7:0]                  dut_d,
  input  wire logic                        dut_oe,
  output logic      [2:0]                  cfg,
  output logic                             hw_standby_input_n_n,
  output logic      [1:0]                  p5,
  output logic                             pgm_n,
  output logic                             oe_n,
  output logic      [orp_pkg::PROM_AW-1:0] addr,
  output logic      [7:0]                  d_in
);
  import orp_pkg::*;
  logic [7:0] drv_d;
  logic       drv;
  // shared data wire, undriven it never holds a stale byte
  assign d_in = dut_oe ? dut_d : (drv ? drv_d : ~drv_d);
  initial begin
    cfg    = 3'h7;
    hw_standby_input_n_n = 1'b1;
    p5     = 2'h0;
    pgm_n  = 1'b1;
    oe_n   = 1'b1;
    addr   = '0;
    drv_d  = 8'h00;
    drv    = 1'b0;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle
  task automatic set_pins(input logic [2:0] c, input logic s, input logic [1:0] p);
    cfg    <= c;
    hw_standby_input_n_n <= s;
    p5     <= p;
    settle(10);
  endtask : set_pins
  // a single byte per strobe, never a page
  task automatic pulse(input logic [16:0] a, input logic [7:0] v, input int w);
    oe_n  <= 1'b1;
    addr  <= a;
    drv_d <= v;
    drv   <= 1'b1;
    settle(8);
    pgm_n <= 1'b0;
    settle(w);
    pgm_n <= 1'b1;
    settle(8); // data held past the strobe end
    drv   <= 1'b0;
  endtask : pulse
  task automatic verify(input logic [16:0] a, output logic [7:0] v, output logic oe);
    addr <= a;
    oe_n <= 1'b0;
    settle(8);
    v  = dut_d;
    oe = dut_oe;
    oe_n <= 1'b1;
    settle(8);
  endtask : verify
  // verify after each pulse, bounded retries, then one overwrite pulse
  task automatic prog_byte(input logic [16:0] a, input logic [7:0] v, output logic ok);
    logic [7:0] rd;
    logic       oe;
    if (a > 17'h0ffff) v = 8'hff;
    ok = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      pulse(a, v, 2000);
      verify(a, rd, oe);
      ok = (rd === v);
    end
    if (ok) pulse(a, v, 2000);
  endtask : prog_byte
endmodule : orp_prog_model

// ---- verif/orp_rom_bench.sv ----
// Purpose: self-checking bench for the on-chip program rom block
// Assumes: 10 mhz clock, 32 kbyte member, short overwrite limit
// Notes:   outputs are sampled at the clock edge, before it updates them
`timescale 1ns/100ps
module orp_rom_bench;
  import orp_pkg::*;
  logic                 clk, rstn, cyc, stb, we, ack, req, cack, ext, ren, susp, doe;
  logic [7:0]           adr, dout;
  logic [3:0]           sel;
  logic [31:0]          wdat, rdat;
  logic [15:0]          crd;
  logic [2:0]           cfg;
  logic [1:0]           p5;
  logic                 hw_standby_input_n_n, pgm_n, oe_n;
  logic [PROM_AW-1:0]   paddr;
  logic [7:0]           din;
  orp_cpu_req_s         info;
  int                   miscompares, checked, cycles;

  orp_rom #(.ROM_BYTES(32768), .OPW_MAX_CYC(3000)) dut (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .cpu_req(req), .cpu_req_info(info), .cpu_ack(cack), .cpu_ext(ext),
    .cpu_rdata(crd), .rom_enabled(ren), .mcu_suspend(susp),
    .boot_cfg_pin_hi(cfg[2]), .boot_cfg_pin_mid(cfg[1]), .boot_cfg_pin_lo(cfg[0]),
    .hw_standby_input_n(hw_standby_input_n_n), .port5_bit1_pin(p5[1]), .port5_bit0_pin(p5[0]),
    .program_strobe_n(pgm_n), .prom_oe_n(oe_n), .prom_address_pins(paddr),
    .prom_data_pins_i(din), .prom_data_pins_o(dout), .prom_data_pins_oe(doe));
  orp_prog_model prog (
    .clk(clk), .dut_d(dout), .dut_oe(doe), .cfg(cfg), .hw_standby_input_n_n(hw_standby_input_n_n), .p5(p5),
    .pgm_n(pgm_n), .oe_n(oe_n), .addr(paddr), .d_in(din));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard, the whole run needs about 8500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h1;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  // n is the edge count from take to answer, 0 when nothing answers
  task automatic cpu(input logic [15:0] a, input logic wd, output logic [15:0] q,
                     output int n, output logic e);
    @(posedge clk);
    req  <= 1'b1;
    info <= '{addr: a, word: wd};
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    e = 1'b0;
    q = 16'h0;
    for (int i = 1; i <= 6 && n == 0; i++) begin
      @(posedge clk);
      if (cack === 1'b1 || ext === 1'b1) begin
        n = i;
        e = ext;
        q = crd;
      end
    end
  endtask : cpu
  task automatic t_regs();
    logic [31:0] q;
    wb(1'b0, REG_CTRL, 32'h0, q);
    check(q[CT_PROG_EN], CT_PROG_EN_RST);
    wb(1'b0, REG_COUNT, 32'h0, q);
    check(q, 32'h0);
    wb(1'b1, 8'h0c, 32'hffff_ffff, q);
    wb(1'b0, 8'h0c, 32'h0, q);
    check(q, 32'h0);
  endtask : t_regs
  task automatic t_modes();
    logic [31:0] st;
    logic [15:0] q;
    int          n;
    logic        e;
    for (int c = 1; c < 8; c++) begin
      prog.set_pins(c[2:0], 1'b1, 2'h0);
      wb(1'b0, REG_STATUS, 32'h0, st);
      check(st[2:0], c[2:0]);
      check({st[ST_ROM_EN], ren}, {2{c >= 5}});
      cpu(16'h0100, 1'b1, q, n, e);
      check(n, (c >= 5) ? 2 : 1);
      check(e, c < 5);
      if (c >= 5) check(q, 16'hffff);
      cpu(16'h0101, 1'b0, q, n, e);
      check(n, (c >= 5) ? 2 : 1);
    end
  endtask : t_modes
  task automatic t_prom();
    logic [31:0] st;
    logic [15:0] q;
    logic [7:0]  d;
    logic        oe, ok, e;
    int          n;
    prog.set_pins(MODE_PROM, 1'b0, 2'h3);
    check(susp, 1'b1);
    cpu(16'h0000, 1'b1, q, n, e);
    check(n, 0);
    prog.verify(17'h00010, d, oe);
    check({oe, d}, {1'b1, ERASED_BYTE});
    check(doe, 1'b0);
    prog.prog_byte(17'h00010, 8'h5a, ok);
    check(ok, 1'b1);
    wb(1'b0, REG_COUNT, 32'h0, st);
    check(st, 32'h2);
    // program enable off: a good pulse must leave the cell alone
    wb(1'b1, REG_CTRL, 32'h0, st);
    prog.pulse(17'h00030, 8'h00, 2000);
    prog.verify(17'h00030, d, oe);
    check(d, 8'hff);
    wb(1'b0, REG_COUNT, 32'h0, st);
    check(st, 32'h2);
    wb(1'b1, REG_CTRL, 32'h1, st);
    prog.pulse(17'h08010, 8'h00, 2000);
    prog.verify(17'h08010, d, oe);
    check(d, 8'hff);
    wb(1'b0, REG_STATUS, 32'h0, st);
    check(st[ST_PULSE_ERR], 1'b1);
    wb(1'b1, REG_STATUS, 32'h1 << ST_PULSE_ERR, st);
    prog.verify(17'h00010, d, oe);
    check(d, 8'h5a);
    prog.pulse(17'h00020, 8'h00, 100);
    wb(1'b0, REG_STATUS, 32'h0, st);
    check(st[ST_PULSE_ERR:ST_PROM], 2'h3);
    prog.verify(17'h00020, d, oe);
    check(d, 8'hff);
    wb(1'b1, REG_STATUS, 32'h1 << ST_PULSE_ERR, st);
    wb(1'b0, REG_STATUS, 32'h0, st);
    check(st[ST_PULSE_ERR], 1'b0);
  endtask : t_prom
  // mid-run reset: registers back to reset values, array kept
  task automatic t_reset();
    logic [31:0] q;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    check({susp, ren, doe, ack}, 4'h0);
    wb(1'b0, REG_COUNT, 32'h0, q);
    check(q, 32'h0);
    wb(1'b0, REG_CTRL, 32'h0, q);
    check(q[CT_PROG_EN], CT_PROG_EN_RST);
  endtask : t_reset
  task automatic t_back();
    logic [15:0] q;
    int          n;
    logic        e;
    prog.set_pins(3'h7, 1'b1, 2'h0);
    cpu(16'h0011, 1'b1, q, n, e);
    check({n[3:0], q}, {4'h2, 16'h5aff});
    cpu(16'h0010, 1'b0, q, n, e);
    check({n[3:0], q}, {4'h2, 16'h5a00});
    cpu(16'h0011, 1'b0, q, n, e);
    check(q, 16'hff00);
  endtask : t_back
  initial begin
    rstn        = 1'b0;
    cyc         = 1'b0;
    stb         = 1'b0;
    we          = 1'b0;
    adr         = 8'h00;
    sel         = 4'h0;
    wdat        = 32'h0;
    req         = 1'b0;
    info        = '0;
    miscompares = 0;
    checked     = 0;
    cycles      = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_modes();
    t_prom();
    t_reset();
    t_back();
    stop_test();
  end
endmodule : orp_rom_bench
